// ---- design/rpm_pkg.sv ----
/*
  Package for the regulator power moding control block: register offset,
  field positions, reset values, power mode encoding and timing counts.
  Assumes an 8-bit register port and a 100 MHz always-on system clock.
*/
package rpm_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam int             RPM_ADDR_W          = 8;
  localparam int             RPM_DATA_W          = 8;
  localparam logic [7:0]     RPM_MISC_OFFSET     = 8'h2f;

  // Field positions inside the miscellaneous power control register.
  localparam int             RPM_REG_ON_BIT      = 0;
  localparam int             RPM_CMP_SEL_BIT     = 1;
  localparam int             RPM_IGN_FLAG_BIT    = 7;

  // Reset values.
  localparam logic           RPM_REG_ON_RST      = 1'b0;
  localparam logic           RPM_CMP_SEL_RST     = 1'b0;
  localparam logic           RPM_LATCH_RST       = 1'b0;
  localparam logic [7:0]     RPM_RDATA_RST       = 8'h00;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int             RPM_SYS_CLK_MHZ     = 100;
  // Start-up delay after an undervoltage reset, in CPU bus clock cycles.
  localparam logic [11:0]    RPM_POR_CYCLES      = 12'h0fe0;
  // System clocks per CPU bus clock; the bus clock is an enable pulse.
  localparam int             RPM_CPU_DIV         = 1;

  // ==========================================================================
  // Power modes
  // ==========================================================================
  typedef enum logic [1:0] {
    RPM_MODE_OFF,
    RPM_MODE_STANDBY,
    RPM_MODE_POWER_UP
  } rpm_mode_e;

endpackage : rpm_pkg

// ---- design/rpm_standby_ctl.sv ----
/*
  Always-on standby part of the regulator control: pin synchronisers,
  wake edge detection and the standby latch that governs the regulator.
  Assumes sys_clk is the always-on clock that keeps running in standby.
*/
`timescale 1ns/1ps

module rpm_standby_ctl
  import rpm_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Pins, asynchronous
  input  wire logic ignition_pin,
  input  wire logic net_bus_pin,
  // Options and register copy
  input  wire logic bus_wake_option,
  input  wire logic copy_wr,
  input  wire logic copy_value,
  // Status
  output logic      ignition_level,
  output logic      wake_pulse,
  output logic      latch_q
);

  // ==========================================================================
  // Synchronisers
  // ==========================================================================
  logic [1:0] pin_meta_reg;
  logic [1:0] pin_sync_reg;
  logic [1:0] pin_prev_reg;
  logic [1:0] pin_raw;
  logic       latch_reg;
  logic       latch_next;
  logic       ign_rise;
  logic       bus_rise;

  assign pin_raw = {net_bus_pin, ignition_pin};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          pin_meta_reg[g] <= 1'b0;
          pin_sync_reg[g] <= 1'b0;
          pin_prev_reg[g] <= 1'b0;
        end else begin
          pin_meta_reg[g] <= pin_raw[g];
          pin_sync_reg[g] <= pin_meta_reg[g];
          pin_prev_reg[g] <= pin_sync_reg[g];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Wake edges and standby latch
  // ==========================================================================
  assign ign_rise       = pin_sync_reg[0] & ~pin_prev_reg[0];
  assign bus_rise       = pin_sync_reg[1] & ~pin_prev_reg[1] & bus_wake_option;
  assign wake_pulse     = ign_rise | bus_rise;
  assign ignition_level = pin_sync_reg[0];

  // A wake edge wins over a register copy in the same cycle.
  assign latch_next = wake_pulse ? 1'b1 :
                      copy_wr    ? copy_value : latch_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      latch_reg <= RPM_LATCH_RST;
    end else begin
      latch_reg <= latch_next;
    end
  end

  assign latch_q = latch_reg;

endmodule : rpm_standby_ctl

// ---- design/rpm_power_ctl.sv ----
/*
  Regulator power moding control: miscellaneous register, standby latch
  instance, regulator enable and clamp, power mode tracking and the
  undervoltage core reset with its start-up delay.
  Assumes supply monitors and option straps arrive asynchronously, and that
  sys_clk keeps running from the always-on supply.
*/
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps

module rpm_power_ctl
  import rpm_pkg::*;
#(
  parameter int CPU_DIV = RPM_CPU_DIV
)
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  // Register port
  input  wire logic [RPM_ADDR_W-1:0] reg_addr,
  input  wire logic [RPM_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [RPM_DATA_W-1:0] reg_rdata,
  // Pins and supply monitors, asynchronous
  input  wire logic                  ignition_pin,
  input  wire logic                  net_bus_pin,
  input  wire logic                  battery_ok,
  input  wire logic                  core_supply_ok,
  // Option straps
  input  wire logic                  regulator_enable_option,
  input  wire logic                  bus_wake_option,
  input  wire logic                  supply_clamp_option,
  // Controls and status
  output logic                       regulator_en,
  output logic                       supply_clamp_en,
  output logic                       shared_pin_cmp_sel,
  output logic                       core_rst_n,
  output logic      [1:0]            power_mode
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  localparam int NSYNC = 5;

  logic [NSYNC-1:0] async_raw;
  logic [NSYNC-1:0] meta_reg;
  logic [NSYNC-1:0] sync_reg;
  logic             battery_ok_s;
  logic             core_ok_s;
  logic             opt_reg_s;
  logic             opt_bus_s;
  logic             opt_clamp_s;

  assign async_raw = {supply_clamp_option, bus_wake_option, regulator_enable_option,
                      core_supply_ok, battery_ok};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          meta_reg[g] <= 1'b0;
          sync_reg[g] <= 1'b0;
        end else begin
          meta_reg[g] <= async_raw[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign battery_ok_s = sync_reg[0];
  assign core_ok_s    = sync_reg[1];
  assign opt_reg_s    = sync_reg[2];
  assign opt_bus_s    = sync_reg[3];
  assign opt_clamp_s  = sync_reg[4];

  // ==========================================================================
  // Register decode
  // ==========================================================================
  function automatic logic misc_hit(input logic [RPM_ADDR_W-1:0] addr);
    misc_hit = (addr == RPM_MISC_OFFSET);
  endfunction : misc_hit

  logic                  wr_hit;
  logic                  rd_hit;
  logic                  reg_on_reg;
  logic                  reg_on_next;
  logic                  cmp_sel_reg;
  logic                  cmp_sel_next;
  logic [RPM_DATA_W-1:0] rdata_reg;
  logic [RPM_DATA_W-1:0] rdata_next;
  logic [RPM_DATA_W-1:0] misc_view;
  logic                  ign_level;
  logic                  ign_flag;
  logic                  wake_pulse;
  logic                  latch_q;
  logic                  core_rst_reg;

  // Writes are taken regardless of the ignition and bus pin levels.
  assign wr_hit = reg_wr & misc_hit(reg_addr);
  assign rd_hit = reg_rd & misc_hit(reg_addr);

  // The register copy ignores core resets; only standby power-on clears it.
  assign reg_on_next = wr_hit ? reg_wdata[RPM_REG_ON_BIT] : reg_on_reg;

  // Core reset clears the compare select and wins over a write.
  assign cmp_sel_next = core_rst_reg ? RPM_CMP_SEL_RST :
                        wr_hit       ? reg_wdata[RPM_CMP_SEL_BIT] : cmp_sel_reg;

  // The flag is the raw synchronised pin, gated by the regulator option.
  assign ign_flag = opt_reg_s & ign_level;

  always_comb begin
    misc_view                   = '0;
    misc_view[RPM_REG_ON_BIT]   = reg_on_reg;
    misc_view[RPM_CMP_SEL_BIT]  = cmp_sel_reg;
    misc_view[RPM_IGN_FLAG_BIT] = ign_flag;
  end

  assign rdata_next = rd_hit ? misc_view : RPM_RDATA_RST;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_on_reg  <= RPM_REG_ON_RST;
      cmp_sel_reg <= RPM_CMP_SEL_RST;
      rdata_reg   <= RPM_RDATA_RST;
    end else begin
      reg_on_reg  <= reg_on_next;
      cmp_sel_reg <= cmp_sel_next;
      rdata_reg   <= rdata_next;
    end
  end

  // ==========================================================================
  // Standby latch in the always-on logic
  // ==========================================================================
  rpm_standby_ctl u_standby (
    .sys_clk         (sys_clk),
    .rstn            (rstn),
    .ignition_pin    (ignition_pin),
    .net_bus_pin     (net_bus_pin),
    .bus_wake_option (opt_bus_s),
    .copy_wr         (wr_hit),
    .copy_value      (reg_wdata[RPM_REG_ON_BIT]),
    .ignition_level  (ign_level),
    .wake_pulse      (wake_pulse),
    .latch_q         (latch_q)
  );

  // ==========================================================================
  // Regulator enable and clamp
  // ==========================================================================
  logic reg_en_reg;
  logic reg_en_next;
  logic clamp_reg;
  logic clamp_next;

  // The latch, not the register copy, drives the regulator.
  assign reg_en_next = opt_reg_s & latch_q;
  // The clamp works from the latch even without the regulator option.
  assign clamp_next  = opt_clamp_s & ~latch_q;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_en_reg <= 1'b0;
      clamp_reg  <= 1'b0;
    end else begin
      reg_en_reg <= reg_en_next;
      clamp_reg  <= clamp_next;
    end
  end

  // ==========================================================================
  // CPU bus clock enable
  // ==========================================================================
  localparam int DIV_W = (CPU_DIV > 1) ? $clog2(CPU_DIV) : 1;

  logic [DIV_W-1:0] div_reg;
  logic             cpu_clk_en;

  assign cpu_clk_en = (div_reg == DIV_W'(CPU_DIV - 1));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_reg <= '0;
    end else begin
      div_reg <= cpu_clk_en ? '0 : div_reg + 1'b1;
    end
  end

  // ==========================================================================
  // Undervoltage reset and start-up delay
  // ==========================================================================
  logic        uv_cond;
  logic [11:0] por_cnt_reg;
  logic [11:0] por_cnt_next;
  logic        por_done;
  logic        core_rst_n_reg;

  // Any loss of regulator output, including software switching it off.
  assign uv_cond      = ~battery_ok_s | ~core_ok_s | ~reg_en_next;
  assign por_done     = (por_cnt_reg == RPM_POR_CYCLES);
  assign por_cnt_next = uv_cond                 ? '0 :
                        (cpu_clk_en & ~por_done) ? por_cnt_reg + 12'h0001 :
                        por_cnt_reg;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      por_cnt_reg    <= '0;
      core_rst_reg   <= 1'b1;
      core_rst_n_reg <= 1'b0;
    end else begin
      por_cnt_reg    <= por_cnt_next;
      core_rst_reg   <= uv_cond | ~por_done;
      core_rst_n_reg <= ~(uv_cond | ~por_done);
    end
  end

  // ==========================================================================
  // Power mode
  // ==========================================================================
  rpm_mode_e mode_reg;
  rpm_mode_e mode_next;

  always_comb begin
    case (mode_reg)
      RPM_MODE_OFF:      mode_next = battery_ok_s ? RPM_MODE_STANDBY : RPM_MODE_OFF;
      RPM_MODE_STANDBY:  mode_next = !battery_ok_s ? RPM_MODE_OFF :
                                     (reg_en_next & core_ok_s) ? RPM_MODE_POWER_UP :
                                     RPM_MODE_STANDBY;
      RPM_MODE_POWER_UP: mode_next = !battery_ok_s ? RPM_MODE_OFF :
                                     (!reg_en_next | !core_ok_s) ? RPM_MODE_STANDBY :
                                     RPM_MODE_POWER_UP;
      default:           mode_next = RPM_MODE_OFF;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= RPM_MODE_OFF;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign reg_rdata          = rdata_reg;
  assign regulator_en       = reg_en_reg;
  assign supply_clamp_en    = clamp_reg;
  assign shared_pin_cmp_sel = cmp_sel_reg;
  assign core_rst_n         = core_rst_n_reg;
  assign power_mode         = mode_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Helper: CPU bus clocks seen since the undervoltage condition last cleared.
  logic [12:0] uv_free_cnt;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      uv_free_cnt <= '0;
    end else if (uv_cond) begin
      uv_free_cnt <= '0;
    end else if (cpu_clk_en && uv_free_cnt != 13'h1fff) begin
      uv_free_cnt <= uv_free_cnt + 13'h0001;
    end
  end

  a_regulator_follows_latch: assert property (
    opt_reg_s && $stable(opt_reg_s) ##1 1'b1 |-> regulator_en == $past(latch_q))
    else $error("regulator enable does not follow the standby latch");

  a_wake_only_enable: assert property (
    !latch_q && !wake_pulse && !(wr_hit && reg_wdata[RPM_REG_ON_BIT]) |=> !latch_q)
    else $error("latch set without wake edge or write");

  a_off_by_software: assert property (
    latch_q && !(wr_hit && !reg_wdata[RPM_REG_ON_BIT]) |=> latch_q)
    else $error("regulator latch cleared without software");

  a_clamp_on_off: assert property (
    opt_clamp_s && !latch_q |=> supply_clamp_en)
    else $error("clamp not on while regulator disabled");

  a_clamp_wake_release: assert property (
    opt_clamp_s && wake_pulse ##1 opt_clamp_s ##1 1'b1 |-> !supply_clamp_en)
    else $error("clamp not released after wake edge");

  a_reset_min_delay: assert property (
    $rose(core_rst_n) |-> uv_free_cnt >= {1'b0, RPM_POR_CYCLES})
    else $error("core reset released before start-up delay");

  a_reset_persists: assert property (
    uv_cond |=> !core_rst_n [*2])
    else $error("core reset released during undervoltage");

  a_flag_readback: assert property (
    rd_hit |=> reg_rdata[RPM_IGN_FLAG_BIT] == $past(ign_flag))
    else $error("ignition flag readback mismatch");

  a_flag_gated: assert property (
    rd_hit && !opt_reg_s |=> !reg_rdata[RPM_IGN_FLAG_BIT])
    else $error("ignition flag visible without regulator option");

  a_compare_clear: assert property (
    !core_rst_n |=> !shared_pin_cmp_sel)
    else $error("compare select not cleared by reset");

  a_wake_sets_latch: assert property (
    wake_pulse |=> latch_q)
    else $error("wake edge did not set the standby latch");

  a_leave_power_up: assert property (
    mode_reg == RPM_MODE_POWER_UP && !reg_en_next |=> !core_rst_n)
    else $error("no undervoltage reset on leaving power-up");

endmodule : rpm_power_ctl

// ---- sim/rpm_pin_model.sv ----
/*
  Far-side model of the ignition sense line and the network bus pin.
  Assumes the bench requests pin levels synchronously to sys_clk.
*/
`timescale 1ns/1ps

module rpm_pin_model (
  // Clock
  input  wire logic sys_clk,
  // Level requests from the bench
  input  wire logic ign_req,
  input  wire logic bus_req,
  input  wire logic battery_ok,
  // Driven pins
  output logic      ignition_pin,
  output logic      net_bus_pin
);
  // ==========================================================================
  // Pin drivers
  // ==========================================================================
  logic [1:0] ign_low_cnt;
  logic [1:0] bus_low_cnt;

  initial begin
    ignition_pin = 1'b0;
    net_bus_pin  = 1'b0;
    ign_low_cnt  = 2'h0;
    bus_low_cnt  = 2'h0;
  end

  // A rise is only made after two low cycles, so every edge is visible.
  always @(posedge sys_clk) begin
    if (!ign_req) ignition_pin <= 1'b0;
    else if (battery_ok && ign_low_cnt == 2'h2) ignition_pin <= 1'b1;
    if (!bus_req) net_bus_pin <= 1'b0;
    else if (bus_low_cnt == 2'h2) net_bus_pin <= 1'b1;
    ign_low_cnt <= ignition_pin ? 2'h0 : (ign_low_cnt == 2'h2 ? 2'h2 : ign_low_cnt + 2'h1);
    bus_low_cnt <= net_bus_pin ? 2'h0 : (bus_low_cnt == 2'h2 ? 2'h2 : bus_low_cnt + 2'h1);
  end
endmodule : rpm_pin_model

// ---- sim/rpm_power_ctl_tb.sv ----
/*
  Self-checking bench for the regulator power moding control block.
  Assumes the pin model drives the wake pins and CPU_DIV is left at 1.
*/
`timescale 1ns/1ps

module rpm_power_ctl_tb;
  import rpm_pkg::*;

  typedef struct {
    logic       ign;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] outs;
  } rpm_row_s;

  logic                  sys_clk;
  logic                  rstn;
  logic [RPM_ADDR_W-1:0] reg_addr;
  logic [RPM_DATA_W-1:0] reg_wdata;
  logic                  reg_wr;
  logic                  reg_rd;
  logic [RPM_DATA_W-1:0] reg_rdata;
  logic                  ignition_pin;
  logic                  net_bus_pin;
  logic                  battery_ok;
  logic                  core_supply_ok;
  logic                  reg_opt;
  logic                  bus_opt;
  logic                  clamp_opt;
  logic                  regulator_en;
  logic                  supply_clamp_en;
  logic                  shared_pin_cmp_sel;
  logic                  core_rst_n;
  logic [1:0]            power_mode;
  logic                  ign_req;
  logic                  bus_req;
  int                    num_errors;
  int                    cmp_count;
  int                    cycles;
  rpm_row_s              rows [5];

  rpm_power_ctl dut (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ignition_pin(ignition_pin), .net_bus_pin(net_bus_pin), .battery_ok(battery_ok),
    .core_supply_ok(core_supply_ok), .regulator_enable_option(reg_opt),
    .bus_wake_option(bus_opt), .supply_clamp_option(clamp_opt),
    .regulator_en(regulator_en), .supply_clamp_en(supply_clamp_en),
    .shared_pin_cmp_sel(shared_pin_cmp_sel), .core_rst_n(core_rst_n),
    .power_mode(power_mode)
  );

  rpm_pin_model pins (
    .sys_clk(sys_clk), .ign_req(ign_req), .bus_req(bus_req), .battery_ok(battery_ok),
    .ignition_pin(ignition_pin), .net_bus_pin(net_bus_pin)
  );

  // ==========================================================================
  // Clock, timeout and shared tasks
  // ==========================================================================
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  task finish_test;
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk("rdata", reg_rdata, exp);
  endtask : rd

  // Counts cycles until the core reset lifts, starting from pre.
  task wait_rel(input int pre);
    int n;
    n = pre;
    while (core_rst_n !== 1'b1 && n < 5000) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk("rel_min", 8'(n >= 4064), 8'h01);
    chk("rel_max", 8'(n <= 4085), 8'h01);
    chk("mode", {6'h0, power_mode}, {6'h0, RPM_MODE_POWER_UP});
  endtask : wait_rel

  function automatic logic [7:0] outs();
    return {5'h0, regulator_en, supply_clamp_en, shared_pin_cmp_sel};
  endfunction : outs

  // Enable, clamp, compare select, core reset and power mode in one byte.
  function automatic logic [7:0] stat();
    return {2'h0, regulator_en, supply_clamp_en, shared_pin_cmp_sel, core_rst_n, power_mode};
  endfunction : stat

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    rows[0] = '{1'b1, RPM_MISC_OFFSET, 8'h01, 8'h81, 8'h04};
    rows[1] = '{1'b1, RPM_MISC_OFFSET, 8'h03, 8'h83, 8'h05};
    rows[2] = '{1'b0, RPM_MISC_OFFSET, 8'h03, 8'h03, 8'h05};
    rows[3] = '{1'b0, 8'h30, 8'hff, 8'h00, 8'h05};
    rows[4] = '{1'b0, RPM_MISC_OFFSET, 8'h01, 8'h01, 8'h04};
    num_errors = 0;
    cmp_count = 0;
    cycles = 0;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    battery_ok = 1'b0;
    core_supply_ok = 1'b0;
    reg_opt = 1'b1;
    bus_opt = 1'b0;
    clamp_opt = 1'b1;
    ign_req = 1'b0;
    bus_req = 1'b0;
    cyc(4);
    chk("rst_outs", stat(), 8'h00);
    @(posedge sys_clk);
    rstn <= 1'b1;
    rd(RPM_MISC_OFFSET, 8'h00);
    @(posedge sys_clk);
    battery_ok     <= 1'b1;
    core_supply_ok <= 1'b1;
    cyc(6);
    chk("standby", stat(), 8'h11);
    @(posedge sys_clk);
    ign_req <= 1'b1;
    wait_rel(0);
    foreach (rows[i]) begin
      @(posedge sys_clk);
      ign_req <= rows[i].ign;
      cyc(6);
      wr(rows[i].addr, rows[i].wdata);
      cyc(3);
      rd(rows[i].addr, rows[i].rdata);
      chk("outs", outs(), rows[i].outs);
      chk("mode", {6'h0, power_mode}, {6'h0, RPM_MODE_POWER_UP});
    end
    // Software switches the regulator off while the ignition pin is low.
    // The latch takes the write at once; enable and clamp follow one cycle later.
    wr(RPM_MISC_OFFSET, 8'h00);
    cyc(1);
    chk("off_en", outs(), 8'h02);
    cyc(4);
    chk("off_rst", stat(), 8'h11);
    @(posedge sys_clk);
    bus_req <= 1'b1;
    cyc(50);
    chk("bus_nowake", outs(), 8'h02);
    @(posedge sys_clk);
    bus_req <= 1'b0;
    bus_opt <= 1'b1;
    cyc(4);
    @(posedge sys_clk);
    bus_req <= 1'b1;
    cyc(6);
    chk("bus_wake", outs(), 8'h04);
    wait_rel(6);
    rd(RPM_MISC_OFFSET, 8'h00);
    wr(RPM_MISC_OFFSET, 8'h03);
    // A supply fault in mid-run holds the core in reset.
    @(posedge sys_clk);
    core_supply_ok <= 1'b0;
    cyc(4);
    chk("uv_rst", {7'h0, core_rst_n}, 8'h00);
    cyc(100);
    chk("uv_hold", {7'h0, core_rst_n}, 8'h00);
    chk("uv_sel", {7'h0, shared_pin_cmp_sel}, 8'h00);
    rd(RPM_MISC_OFFSET, 8'h01);
    @(posedge sys_clk);
    core_supply_ok <= 1'b1;
    wait_rel(0);
    // Without the regulator option the clamp and register still work.
    @(posedge sys_clk);
    reg_opt <= 1'b0;
    bus_req <= 1'b0;
    ign_req <= 1'b1;
    cyc(8);
    rd(RPM_MISC_OFFSET, 8'h01);
    wr(RPM_MISC_OFFSET, 8'h00);
    cyc(3);
    chk("nopt_clamp", {7'h0, supply_clamp_en}, 8'h01);
    wr(RPM_MISC_OFFSET, 8'h01);
    cyc(3);
    chk("nopt_clr", {7'h0, supply_clamp_en}, 8'h00);
    chk("nopt_en", {7'h0, regulator_en}, 8'h00);
    // A second standby reset clears everything at once.
    @(posedge sys_clk);
    rstn <= 1'b0;
    ign_req <= 1'b0;
    #1;
    chk("rst2_outs", stat(), 8'h00);
    cyc(4);
    @(posedge sys_clk);
    rstn    <= 1'b1;
    reg_opt <= 1'b1;
    cyc(4);
    rd(RPM_MISC_OFFSET, 8'h00);
    finish_test();
  end
endmodule : rpm_power_ctl_tb
